/* File: common/mcc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the MAC command block
`ifndef MCC_CFG_SVH
`define MCC_CFG_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define MCC_OFF_CAM_ENTRY_ENABLE      32'hB000_3004
`define MCC_OFF_CAM13M     32'hB000_3070
`define MCC_CAM_WORDS      6
`define MCC_OFF_TXLS       32'hB000_3088
`define MCC_OFF_RXLS       32'hB000_308C
`define MCC_OFF_MCMD       32'hB000_3090
`define MCC_OFF_CTXD       32'hB000_30CC
`define MCC_OFF_CRXD       32'hB000_30D4

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define MCC_B_SWR          24
`define MCC_B_LBK          21
`define MCC_B_SPEED        20
`define MCC_B_MDC          19
`define MCC_B_FULL_DUPLEX         18
`define MCC_B_SQE          17
`define MCC_B_PAUSE        16
`define MCC_B_NO_DEFER         9
`define MCC_B_TXEN         8
`define MCC_B_STRIP        5
`define MCC_B_ACRC         4
`define MCC_B_ACTL         3
`define MCC_B_ARUNT        2
`define MCC_B_ALONG        1
`define MCC_B_RXEN         0
`define MCC_MCMD_MASK      32'h013F_033F
`define MCC_MCMD_KEEP      32'h0030_0000
`define MCC_CAM_ENTRY_ENABLE_MASK     32'h0000_FFFF
`define MCC_CAML_MASK      32'hFFFF_0000
`define MCC_CAM_ENTRY_ENABLE_PAUSE    32'h0000_E000
`define MCC_ADDR_MASK      32'hFFFF_FFFC

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MCC_RST_TXLS       32'hFFFF_FFFC
`define MCC_RST_RXLS       32'hFFFF_FFFC
`define MCC_RST_MCMD       32'h0000_0000
`define MCC_RST_PAUSE_TO   32'h8808_0001
`define MCC_RST_ZERO       32'h0000_0000

// ----------------------------------------
// Timing and frame figures
// ----------------------------------------
`define MCC_CLK_NS         4
`define MCC_SRST_NS        32
`define MCC_SRST_CYC       ((`MCC_SRST_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)
`define MCC_HDR_BYTES      18
`define MCC_PAD_END        60
`define MCC_FRAME_BYTES    64
`define MCC_CRC_BYTES      16'd4
`define MCC_RUNT_MIN       16'd64
`define MCC_LONG_MAX       16'd1518
`define MCC_CRC_POLY       32'hEDB8_8320
`define MCC_CRC_INIT       32'hFFFF_FFFF

`endif

/* File: common/mcc_pkg.sv */
// Types shared by the MAC command block
package mcc_pkg;
   typedef logic [31:0] mcc_word_t;
   typedef logic [7:0]  mcc_byte_t;
   typedef enum logic   {PS_IDLE, PS_SEND} mcc_pause_e;
endpackage

/* File: src/mcc_top.sv */
// MAC command, descriptor list start and PAUSE frame logic
`timescale 1ns/1ps
`include "mcc_cfg.svh"
module mcc_top
(
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire mcc_pkg::mcc_word_t reg_addr,
   input  wire mcc_pkg::mcc_word_t reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output mcc_pkg::mcc_word_t     reg_rdata,
   input  wire logic              tx_pkt_busy,
   input  wire logic              rx_pkt_busy,
   input  wire logic              tx_desc_advance,
   input  wire mcc_pkg::mcc_word_t tx_desc_next_addr,
   input  wire logic              rx_desc_advance,
   input  wire mcc_pkg::mcc_word_t rx_desc_next_addr,
   output logic                   tx_run,
   output logic                   rx_run,
   output mcc_pkg::mcc_word_t     current_tx_descriptor_addr,
   output mcc_pkg::mcc_word_t     current_rx_descriptor_addr,
   output logic                   soft_reset_active,
   output logic                   loopback_select,
   output logic                   speed_mode,
   output logic                   full_duplex_active,
   output logic                   mgmt_clock_enable,
   output logic                   sqe_check_active,
   output logic                   defer_counter_enable,
   input  wire logic              rx_done,
   input  wire logic [15:0]       rx_len,
   input  wire logic              rx_crc_error,
   input  wire logic              rx_control,
   output logic                   rx_verdict_valid,
   output logic                   rx_accept,
   output logic [15:0]            rx_recorded_len,
   output mcc_pkg::mcc_byte_t     pause_tx_data,
   output logic                   pause_tx_valid,
   output logic                   pause_tx_last,
   input  wire logic              pause_tx_ready,
   output logic                   pause_busy
);
   import mcc_pkg::*;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic       wr_cam_entry_enable;
   logic       wr_txls;
   logic       wr_rxls;
   logic       wr_cmd;
   mcc_word_t  cam_entry_enable_r;
   mcc_word_t  txls_r;
   mcc_word_t  rxls_r;
   mcc_word_t  cmd_r;
   mcc_word_t  cmd_nxt;
   mcc_word_t  ctxd_r;
   mcc_word_t  crxd_r;
   mcc_word_t  cam_r [0:`MCC_CAM_WORDS-1];
   mcc_word_t  rd_word;
   mcc_word_t  rdata_r;
   logic       srst_r;
   logic [3:0] srst_cnt_r;
   logic       tx_run_r;
   logic       rx_run_r;
   logic       tx_en_rise;
   logic       rx_en_rise;
   logic       pause_done;
   logic       pause_set;

   assign wr_cam_entry_enable = reg_wr & (reg_addr == `MCC_OFF_CAM_ENTRY_ENABLE);
   assign wr_txls  = reg_wr & (reg_addr == `MCC_OFF_TXLS);
   assign wr_rxls  = reg_wr & (reg_addr == `MCC_OFF_RXLS);
   assign wr_cmd   = reg_wr & (reg_addr == `MCC_OFF_MCMD);
   assign pause_set = wr_cmd & reg_wdata[`MCC_B_PAUSE];

   // ----------------------------------------
   // Pause entry words
   // ----------------------------------------
   genvar k;
   generate
      for (k = 0; k < `MCC_CAM_WORDS; k = k + 1)
      begin : g_cam
         localparam mcc_word_t OFF  = `MCC_OFF_CAM13M + 32'(k * 4);
         localparam mcc_word_t MSK  = (k % 2 == 1) ? `MCC_CAML_MASK : 32'hFFFF_FFFF;
         localparam mcc_word_t RSTV = (k == 4) ? `MCC_RST_PAUSE_TO : `MCC_RST_ZERO;
         always_ff @(posedge core_clk or negedge reset_n)
         begin
            if (!reset_n)
               cam_r[k] <= RSTV;
            else if (srst_r)
               cam_r[k] <= RSTV;
            else if (reg_wr && reg_addr == OFF)
               cam_r[k] <= reg_wdata & MSK;
         end
      end
   endgenerate

   // ----------------------------------------
   // Command register next value
   // ----------------------------------------
   always_comb
   begin
      cmd_nxt = cmd_r;
      if (wr_cmd)
         cmd_nxt = reg_wdata & `MCC_MCMD_MASK;
      if (pause_done && !pause_set)
         cmd_nxt[`MCC_B_PAUSE] = 1'b0;
      if (srst_r)
         cmd_nxt = cmd_r & `MCC_MCMD_KEEP;
      cmd_nxt[`MCC_B_SWR] = 1'b0;
   end
   assign tx_en_rise = cmd_nxt[`MCC_B_TXEN] & ~cmd_r[`MCC_B_TXEN];
   assign rx_en_rise = cmd_nxt[`MCC_B_RXEN] & ~cmd_r[`MCC_B_RXEN];

   // ----------------------------------------
   // Soft reset sequencer
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         srst_r     <= 1'b0;
         srst_cnt_r <= 4'h0;
      end
      else if (wr_cmd && reg_wdata[`MCC_B_SWR])
      begin
         srst_r     <= 1'b1;
         srst_cnt_r <= 4'(`MCC_SRST_CYC - 1);
      end
      else if (srst_r)
      begin
         srst_r     <= (srst_cnt_r != 4'h0);
         srst_cnt_r <= srst_cnt_r - 4'h1;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cmd_r   <= `MCC_RST_MCMD;
         cam_entry_enable_r <= `MCC_RST_ZERO;
         txls_r  <= `MCC_RST_TXLS;
         rxls_r  <= `MCC_RST_RXLS;
      end
      else
      begin
         cmd_r <= cmd_nxt;
         if (srst_r)
         begin
            cam_entry_enable_r <= `MCC_RST_ZERO;
            txls_r  <= `MCC_RST_TXLS;
            rxls_r  <= `MCC_RST_RXLS;
         end
         else
         begin
            if (wr_cam_entry_enable)
               cam_entry_enable_r <= reg_wdata & `MCC_CAM_ENTRY_ENABLE_MASK;
            if (wr_txls)
               txls_r <= reg_wdata;
            if (wr_rxls)
               rxls_r <= reg_wdata;
         end
      end
   end

   // ----------------------------------------
   // Current descriptor addresses and run state
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctxd_r   <= `MCC_RST_ZERO;
         crxd_r   <= `MCC_RST_ZERO;
         tx_run_r <= 1'b0;
         rx_run_r <= 1'b0;
      end
      else if (srst_r)
      begin
         ctxd_r   <= `MCC_RST_ZERO;
         crxd_r   <= `MCC_RST_ZERO;
         tx_run_r <= 1'b0;
         rx_run_r <= 1'b0;
      end
      else
      begin
         if (tx_en_rise)
            ctxd_r <= txls_r & `MCC_ADDR_MASK;
         else if (tx_desc_advance)
            ctxd_r <= tx_desc_next_addr & `MCC_ADDR_MASK;
         if (rx_en_rise)
            crxd_r <= rxls_r & `MCC_ADDR_MASK;
         else if (rx_desc_advance)
            crxd_r <= rx_desc_next_addr & `MCC_ADDR_MASK;
         tx_run_r <= cmd_r[`MCC_B_TXEN] | (tx_run_r & tx_pkt_busy);
         rx_run_r <= cmd_r[`MCC_B_RXEN] | (rx_run_r & rx_pkt_busy);
      end
   end

   // ----------------------------------------
   // Mode outputs
   // ----------------------------------------
   assign tx_run               = tx_run_r;
   assign rx_run               = rx_run_r;
   assign current_tx_descriptor_addr = ctxd_r;
   assign current_rx_descriptor_addr = crxd_r;
   assign soft_reset_active    = srst_r;
   assign loopback_select      = cmd_r[`MCC_B_LBK];
   assign speed_mode           = cmd_r[`MCC_B_SPEED];
   assign full_duplex_active   = cmd_r[`MCC_B_FULL_DUPLEX] | cmd_r[`MCC_B_LBK];
   assign mgmt_clock_enable    = cmd_r[`MCC_B_MDC];
   assign sqe_check_active     = cmd_r[`MCC_B_SQE] & ~speed_mode & ~full_duplex_active;
   assign defer_counter_enable = ~cmd_r[`MCC_B_NO_DEFER] & ~full_duplex_active;

   // ----------------------------------------
   // Receive acceptance filter
   // ----------------------------------------
   logic        rx_drop;
   logic [15:0] rx_len_cut;
   logic        rx_acc_r;
   logic        rx_vld_r;
   logic [15:0] rx_rlen_r;
   assign rx_drop = (rx_crc_error & ~cmd_r[`MCC_B_ACRC])
                  | (rx_control & ~cmd_r[`MCC_B_ACTL])
                  | ((rx_len < `MCC_RUNT_MIN) & ~cmd_r[`MCC_B_ARUNT])
                  | ((rx_len > `MCC_LONG_MAX) & ~cmd_r[`MCC_B_ALONG]);
   assign rx_len_cut = (rx_len < `MCC_CRC_BYTES) ? 16'h0000 : rx_len - `MCC_CRC_BYTES;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_vld_r  <= 1'b0;
         rx_acc_r  <= 1'b0;
         rx_rlen_r <= 16'h0000;
      end
      else
      begin
         rx_vld_r <= rx_done & ~srst_r;
         rx_acc_r <= rx_done & ~srst_r & rx_run_r & ~rx_drop;
         if (rx_done)
            rx_rlen_r <= cmd_r[`MCC_B_STRIP] ? rx_len_cut : rx_len;
      end
   end
   assign rx_verdict_valid = rx_vld_r;
   assign rx_accept        = rx_acc_r;
   assign rx_recorded_len  = rx_rlen_r;

   // ----------------------------------------
   // Pause frame generator
   // ----------------------------------------
   function automatic mcc_word_t mcc_crc8(input mcc_word_t c, input mcc_byte_t d);
      mcc_word_t r;
      r = c;
      for (int i = 0; i < 8; i = i + 1)
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `MCC_CRC_POLY) : (r >> 1);
      return r;
   endfunction
   mcc_pause_e   ps_r;
   logic [5:0]   idx_r;
   mcc_word_t    crc_r;
   mcc_word_t    crc_fin;
   mcc_byte_t    out_data_r;
   logic         out_valid_r;
   logic         out_last_r;
   logic [143:0] hdr;
   logic [7:0]   hdr_off;
   mcc_byte_t    hdr_byte;
   mcc_byte_t    byte_cur;
   logic         load_ok;
   logic         more;
   logic         cams_ok;
   logic         pause_go;
   assign hdr      = {cam_r[0], cam_r[1][31:16], cam_r[2], cam_r[3][31:16],
                      cam_r[4], cam_r[5][31:16]};
   assign hdr_off  = 8'd143 - {idx_r[4:0], 3'b000};
   assign hdr_byte = hdr[hdr_off -: 8];
   assign crc_fin  = ~crc_r;
   assign byte_cur = (idx_r < 6'(`MCC_HDR_BYTES)) ? hdr_byte :
                     (idx_r < 6'(`MCC_PAD_END))   ? 8'h00    :
                     crc_fin[{idx_r[1:0], 3'b000} +: 8];
   assign load_ok  = ~out_valid_r | pause_tx_ready;
   assign more     = (ps_r == PS_SEND) & ~(out_valid_r & out_last_r);
   assign cams_ok  = ((cam_entry_enable_r & `MCC_CAM_ENTRY_ENABLE_PAUSE) == `MCC_CAM_ENTRY_ENABLE_PAUSE);
   assign pause_go = (ps_r == PS_IDLE) & cmd_r[`MCC_B_PAUSE] & cams_ok & ~srst_r & ~tx_pkt_busy;
   assign pause_done = out_valid_r & out_last_r & pause_tx_ready;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ps_r        <= PS_IDLE;
         idx_r       <= 6'h00;
         crc_r       <= `MCC_CRC_INIT;
         out_data_r  <= 8'h00;
         out_valid_r <= 1'b0;
         out_last_r  <= 1'b0;
      end
      else if (srst_r)
      begin
         ps_r        <= PS_IDLE;
         out_valid_r <= 1'b0;
         out_last_r  <= 1'b0;
      end
      else
      begin
         unique case (ps_r)
            PS_IDLE:
               if (pause_go)
               begin
                  ps_r  <= PS_SEND;
                  idx_r <= 6'h00;
                  crc_r <= `MCC_CRC_INIT;
               end
            PS_SEND:
            begin
               if (pause_done)
               begin
                  ps_r        <= PS_IDLE;
                  out_valid_r <= 1'b0;
                  out_last_r  <= 1'b0;
               end
               else if (load_ok && more)
               begin
                  out_data_r  <= byte_cur;
                  out_valid_r <= 1'b1;
                  out_last_r  <= (idx_r == 6'(`MCC_FRAME_BYTES - 1));
                  idx_r       <= idx_r + 6'h01;
                  if (idx_r < 6'(`MCC_PAD_END))
                     crc_r <= mcc_crc8(crc_r, byte_cur);
               end
            end
         endcase
      end
   end

   assign pause_tx_data  = out_data_r;
   assign pause_tx_valid = out_valid_r;
   assign pause_tx_last  = out_last_r;
   assign pause_busy     = (ps_r == PS_SEND);

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   always_comb
   begin
      unique case (reg_addr)
         `MCC_OFF_CAM_ENTRY_ENABLE:       rd_word = cam_entry_enable_r;
         `MCC_OFF_CAM13M:      rd_word = cam_r[0];
         `MCC_OFF_CAM13M + 4:  rd_word = cam_r[1];
         `MCC_OFF_CAM13M + 8:  rd_word = cam_r[2];
         `MCC_OFF_CAM13M + 12: rd_word = cam_r[3];
         `MCC_OFF_CAM13M + 16: rd_word = cam_r[4];
         `MCC_OFF_CAM13M + 20: rd_word = cam_r[5];
         `MCC_OFF_TXLS:        rd_word = txls_r;
         `MCC_OFF_RXLS:        rd_word = rxls_r;
         `MCC_OFF_MCMD:        rd_word = cmd_r | ({31'h0, srst_r} << `MCC_B_SWR);
         `MCC_OFF_CTXD:        rd_word = ctxd_r;
         `MCC_OFF_CRXD:        rd_word = crxd_r;
         default:              rd_word = `MCC_RST_ZERO;
      endcase
   end
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata_r <= `MCC_RST_ZERO;
      else
         rdata_r <= reg_rd ? rd_word : `MCC_RST_ZERO;
   end
   assign reg_rdata = rdata_r;
endmodule

/* File: tb/mcc_phy_model.sv */
// Far side model: byte sink for the pause frame stream, prompt or stalling
`timescale 1ns/1ps
module mcc_phy_model
(
   input  wire logic core_clk,
   input  wire logic reset_n,
   input  wire logic slow,
   input  wire logic pause_tx_valid,
   output logic      pause_tx_ready
);
   // ----------------------------------------
   // Ready pacing
   // ----------------------------------------
   logic [2:0] pace_r;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pace_r         <= 3'h0;
         pause_tx_ready <= 1'b0;
      end
      else
      begin
         if (pause_tx_valid)
            pace_r <= pace_r + 3'h1;
         pause_tx_ready <= !slow || pace_r == 3'h2 || pace_r == 3'h5;
      end
   end
endmodule

/* File: tb/mcc_asserts.sv */
// Checker of descriptor load, run control, mode gating, soft reset and pause framing
`timescale 1ns/1ps
`include "mcc_cfg.svh"
module mcc_asserts
(
   input wire logic               core_clk,
   input wire logic               reset_n,
   input wire mcc_pkg::mcc_word_t reg_addr,
   input wire mcc_pkg::mcc_word_t reg_wdata,
   input wire logic               reg_wr,
   input wire logic               tx_pkt_busy,
   input wire logic               tx_run,
   input wire mcc_pkg::mcc_word_t current_tx_descriptor_addr,
   input wire logic               soft_reset_active,
   input wire logic               loopback_select,
   input wire logic               speed_mode,
   input wire logic               full_duplex_active,
   input wire logic               sqe_check_active,
   input wire logic               defer_counter_enable,
   input wire logic               rx_done,
   input wire logic               rx_verdict_valid,
   input wire mcc_pkg::mcc_byte_t pause_tx_data,
   input wire logic               pause_tx_valid,
   input wire logic               pause_tx_last,
   input wire logic               pause_tx_ready
);
   import mcc_pkg::*;
   // ----------------------------------------
   // Shadow state
   // ----------------------------------------
   mcc_word_t  txls_r;
   logic       txen_r;
   logic [5:0] hs_cnt_r;
   wire        cmd_wr = reg_wr && reg_addr == `MCC_OFF_MCMD && !soft_reset_active;
   wire        ls_wr  = reg_wr && reg_addr == `MCC_OFF_TXLS && !soft_reset_active;
   wire        hs     = pause_tx_valid && pause_tx_ready;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txls_r   <= `MCC_RST_TXLS;
         txen_r   <= 1'b0;
         hs_cnt_r <= 6'h00;
      end
      else if (soft_reset_active)
      begin
         txls_r   <= `MCC_RST_TXLS;
         txen_r   <= 1'b0;
         hs_cnt_r <= 6'h00;
      end
      else
      begin
         txls_r   <= ls_wr ? reg_wdata : txls_r;
         txen_r   <= cmd_wr ? reg_wdata[`MCC_B_TXEN] : txen_r;
         hs_cnt_r <= hs ? hs_cnt_r + 6'h01 : hs_cnt_r;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   sequence txen_rise_s;
      cmd_wr && reg_wdata[`MCC_B_TXEN] && !reg_wdata[`MCC_B_SWR] && !txen_r;
   endsequence
   sequence swr_s;
      cmd_wr && reg_wdata[`MCC_B_SWR];
   endsequence
   tx_load_a: assert property (txen_rise_s |=> current_tx_descriptor_addr == (txls_r & `MCC_ADDR_MASK))
      else $error("current tx descriptor address not loaded from list start");
   tx_start_a: assert property (txen_rise_s |-> ##2 tx_run)
      else $error("tx engine did not start two cycles after enable");
   tx_hold_a: assert property (tx_run && tx_pkt_busy && !soft_reset_active ##1 !soft_reset_active |-> tx_run)
      else $error("tx engine stopped inside a packet");
   srst_len_a: assert property (swr_s |=> soft_reset_active[*8] ##1 !soft_reset_active)
      else $error("soft reset length wrong");
   lbk_fdx_a: assert property (loopback_select |-> full_duplex_active)
      else $error("loopback without full duplex");
   sqe_gate_a: assert property (sqe_check_active |-> !speed_mode && !full_duplex_active)
      else $error("sqe check active outside slow half duplex");
   defer_gate_a: assert property (full_duplex_active |-> !defer_counter_enable)
      else $error("deferral counter enabled in full duplex");
   verdict_due_a: assert property (rx_done && !soft_reset_active |=> rx_verdict_valid)
      else $error("no verdict after frame end");
   verdict_cause_a: assert property (rx_verdict_valid |-> $past(rx_done))
      else $error("verdict without frame end");
   pause_hold_a: assert property (pause_tx_valid && !pause_tx_ready |=> pause_tx_valid && $stable(pause_tx_data))
      else $error("pause byte changed while stalled");
   pause_last_a: assert property (hs |-> pause_tx_last == (hs_cnt_r == 6'h3F))
      else $error("pause frame last byte not at byte 63");
endmodule
bind mcc_top mcc_asserts chk_u
(
   .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .tx_pkt_busy, .tx_run,
   .current_tx_descriptor_addr, .soft_reset_active, .loopback_select, .speed_mode,
   .full_duplex_active, .sqe_check_active, .defer_counter_enable, .rx_done, .rx_verdict_valid,
   .pause_tx_data, .pause_tx_valid, .pause_tx_last, .pause_tx_ready
);

/* File: tb/ethernet_mac_command_control_tb.sv */
// Self-checking bench of the MAC command block
`timescale 1ns/1ps
`include "mcc_cfg.svh"
module ethernet_mac_command_control_tb;
   import mcc_pkg::*;
   // ----------------------------------------
   // Signals and bookkeeping
   // ----------------------------------------
   logic        core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
   logic        tx_pkt_busy = 1'b0, rx_pkt_busy = 1'b0, tx_desc_advance = 1'b0, rx_desc_advance = 1'b0;
   logic        rx_done = 1'b0, rx_crc_error = 1'b0, rx_control = 1'b0, rd_d = 1'b0;
   logic [15:0] rx_len = 16'h0000, rx_recorded_len;
   mcc_word_t   reg_addr = 32'h0, reg_wdata = 32'h0, tx_desc_next_addr = 32'h0, rx_desc_next_addr = 32'h0;
   mcc_word_t   seed = 32'h0000_F960, reg_rdata;
   mcc_byte_t   pause_tx_data;
   logic        tx_run, rx_run, loopback_select, speed_mode, full_duplex_active, mgmt_clock_enable;
   logic        sqe_check_active, defer_counter_enable, rx_verdict_valid, rx_accept;
   logic        pause_tx_valid, pause_tx_last, pause_tx_ready, pause_busy;
   mcc_word_t   rd_q[$], rx_q[$], pz_q[$];
   int          n_fail = 0, checked = 0;
   always #2 core_clk = ~core_clk;
   mcc_top dut_u
   (
      .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_pkt_busy, .rx_pkt_busy,
      .tx_desc_advance, .tx_desc_next_addr, .rx_desc_advance, .rx_desc_next_addr, .tx_run, .rx_run,
      .current_tx_descriptor_addr(), .current_rx_descriptor_addr(), .soft_reset_active(), .loopback_select,
      .speed_mode, .full_duplex_active, .mgmt_clock_enable, .sqe_check_active, .defer_counter_enable,
      .rx_done, .rx_len, .rx_crc_error, .rx_control, .rx_verdict_valid, .rx_accept, .rx_recorded_len,
      .pause_tx_data, .pause_tx_valid, .pause_tx_last, .pause_tx_ready, .pause_busy
   );
   mcc_phy_model phy_u (.core_clk, .reset_n, .slow, .pause_tx_valid, .pause_tx_ready);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic mcc_word_t xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(string nm, mcc_word_t seen, mcc_word_t exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(mcc_word_t a, mcc_word_t d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      cyc(1);
      reg_wr    <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(mcc_word_t a, mcc_word_t e);
      rd_q.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      cyc(1);
      reg_rd   <= 1'b0;
      cyc(1);
   endtask
   task automatic test_done();
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // Result monitor
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      if (rd_d)
         chk("reg_rdata", reg_rdata, rd_q.size() ? rd_q.pop_front() : 'x);
      if (rx_verdict_valid)
         chk("rx verdict", {rx_accept, rx_recorded_len}, rx_q.size() ? rx_q.pop_front() : 'x);
      if (pause_tx_valid && pause_tx_ready)
         chk("pause byte", {pause_tx_last, pause_tx_data}, pz_q.size() ? pz_q.pop_front() : 'x);
      rd_d <= reg_rd;
   end
   initial
   begin
      cyc(20000);
      n_fail++;
      test_done();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      mcc_word_t    a, b, f, r, c;
      mcc_word_t    e[4];
      logic [143:0] hdr;
      logic [15:0]  ln;
      mcc_byte_t    d;
      logic         fd, acc;
      cyc(12);
      reset_n <= 1'b1;
      cyc(1);
      rd(`MCC_OFF_TXLS, `MCC_RST_TXLS);
      rd(`MCC_OFF_RXLS, `MCC_RST_RXLS);
      rd(`MCC_OFF_MCMD, `MCC_RST_MCMD);
      rd(`MCC_OFF_CAM13M + 32'h10, `MCC_RST_PAUSE_TO);
      rd(32'hB000_3094, `MCC_RST_ZERO);
      a = xs();
      wr(`MCC_OFF_CAM13M + 32'h14, a);
      rd(`MCC_OFF_CAM13M + 32'h14, a & `MCC_CAML_MASK);
      a = xs();
      b = xs();
      wr(`MCC_OFF_TXLS, a);
      wr(`MCC_OFF_RXLS, b);
      wr(`MCC_OFF_MCMD, 32'h0000_0101);
      rd(`MCC_OFF_CTXD, a & `MCC_ADDR_MASK);
      rd(`MCC_OFF_CRXD, b & `MCC_ADDR_MASK);
      rd(`MCC_OFF_TXLS, a);
      rd(`MCC_OFF_RXLS, b);
      tx_desc_next_addr <= xs();
      rx_desc_next_addr <= xs();
      tx_desc_advance   <= 1'b1;
      rx_desc_advance   <= 1'b1;
      cyc(1);
      tx_desc_advance   <= 1'b0;
      rx_desc_advance   <= 1'b0;
      wr(`MCC_OFF_MCMD, 32'h0000_0101);
      rd(`MCC_OFF_CTXD, tx_desc_next_addr & `MCC_ADDR_MASK);
      rd(`MCC_OFF_CRXD, rx_desc_next_addr & `MCC_ADDR_MASK);
      tx_pkt_busy <= 1'b1;
      rx_pkt_busy <= 1'b1;
      wr(`MCC_OFF_MCMD, 32'h0);
      cyc(2);
      @(negedge core_clk);
      chk("run in packet", {tx_run, rx_run}, 32'h3);
      @(posedge core_clk);
      tx_pkt_busy <= 1'b0;
      rx_pkt_busy <= 1'b0;
      cyc(3);
      @(negedge core_clk);
      chk("run after packet", {tx_run, rx_run}, 32'h0);
      @(posedge core_clk);
      for (int i = 0; i < 32; i++)
      begin
         wr(`MCC_OFF_MCMD, {10'h0, i[0], i[1], i[0] ^ i[2], i[2], i[3], 7'h0, i[4], 9'h0});
         fd = i[2] | i[0];
         @(negedge core_clk);
         chk("mode outputs", {loopback_select, speed_mode, mgmt_clock_enable, full_duplex_active, sqe_check_active,
             defer_counter_enable}, {i[0], i[1], i[0] ^ i[2], fd, i[3] & !i[1] & !fd, !i[4] & !fd});
         @(posedge core_clk);
      end
      wr(`MCC_OFF_TXLS, xs());
      wr(`MCC_OFF_MCMD, 32'h013F_033E);
      wr(`MCC_OFF_MCMD, 32'h0000_0001);
      rd(`MCC_OFF_MCMD, 32'h0130_0000);
      cyc(10);
      rd(`MCC_OFF_MCMD, `MCC_MCMD_KEEP);
      rd(`MCC_OFF_TXLS, `MCC_RST_TXLS);
      for (int i = 0; i < 40; i++)
      begin
         f = xs() & 32'h0000_003E;
         r = xs();
         wr(`MCC_OFF_MCMD, f | 32'h1);
         case (r[2:0])
            3'h0: ln = `MCC_RUNT_MIN - 16'h0001;
            3'h1: ln = `MCC_RUNT_MIN;
            3'h2: ln = `MCC_LONG_MAX;
            3'h3: ln = `MCC_LONG_MAX + 16'h0001;
            3'h4: ln = 16'h0003;
            default: ln = {5'h00, r[18:8]};
         endcase
         acc = !(r[20] && !f[4] || r[21] && !f[3] || ln < `MCC_RUNT_MIN && !f[2] || ln > `MCC_LONG_MAX && !f[1]);
         rx_q.push_back({acc, f[5] ? (ln < `MCC_CRC_BYTES ? 16'h0000 : ln - `MCC_CRC_BYTES) : ln});
         rx_len       <= ln;
         rx_crc_error <= r[20];
         rx_control   <= r[21];
         rx_done      <= 1'b1;
         cyc(1);
         rx_done      <= 1'b0;
         cyc(1);
      end
      for (int k = 0; k < 4; k++)
      begin
         e[k] = xs();
         wr(`MCC_OFF_CAM13M + 32'(4 * k), e[k]);
      end
      a = xs();
      wr(`MCC_OFF_CAM13M + 32'h14, a);
      wr(`MCC_OFF_CAM_ENTRY_ENABLE, `MCC_CAM_ENTRY_ENABLE_PAUSE);
      hdr = {e[0], e[1][31:16], e[2], e[3][31:16], `MCC_RST_PAUSE_TO, a[31:16]};
      c = `MCC_CRC_INIT;
      for (int k = 0; k < `MCC_PAD_END; k++)
      begin
         d = (k < `MCC_HDR_BYTES) ? hdr[143 - 8 * k -: 8] : 8'h00;
         pz_q.push_back({24'h0, d});
         c = c ^ {24'h0, d};
         repeat (8) c = c[0] ? (c >> 1) ^ `MCC_CRC_POLY : c >> 1;
      end
      c = ~c;
      for (int k = 0; k < 4; k++)
         pz_q.push_back({23'h0, k == 3, c[8 * k +: 8]});
      slow <= 1'b1;
      wr(`MCC_OFF_MCMD, 32'h0001_0000);
      for (int k = 0; k < 2000 && (pz_q.size() != 0 || pause_busy !== 1'b0); k++)
         cyc(1);
      cyc(2);
      rd(`MCC_OFF_MCMD, 32'h0);
      chk("pause bytes left", pz_q.size(), 32'h0);
      cyc(4);
      chk("results left", rd_q.size() + rx_q.size(), 32'h0);
      test_done();
   end
endmodule
